// *** logic/ddr_ext_cfg_pkg.sv ***
/*
  Constants for the extended configuration decode of the memory device:
  command encodings, word selects, field positions, reset values and codes.
  Assumes nothing of its surroundings; used by every design file.
*/
`default_nettype none
package ddr_ext_cfg_pkg;
  // ------------------------------------------------------------------
  // bus widths
  // ------------------------------------------------------------------
  localparam int unsigned BANK_W   = 3;
  localparam int unsigned ADDR_W   = 13;
  localparam int unsigned CFG_W    = 13;
  localparam int unsigned CMD_W    = 3;
  localparam int unsigned AL_W     = 3;
  localparam int unsigned CL_W     = 3;
  localparam int unsigned LAT_W    = 4;
  localparam int unsigned CAL_W    = 3;
  localparam int unsigned PWR_W    = 2;
  localparam int unsigned RTT_W    = 2;
  localparam int unsigned POST_W   = BANK_W + ADDR_W;
  localparam int unsigned AL_STAGES = 6;

  // ------------------------------------------------------------------
  // command encodings {row, column, write strobe}, all active low
  // ------------------------------------------------------------------
  localparam logic [CMD_W-1:0] CMD_LOAD_CONFIG = 3'h0;
  localparam logic [CMD_W-1:0] CMD_WRITE       = 3'h4;
  localparam logic [CMD_W-1:0] CMD_READ        = 3'h5;

  // bank address picks the configuration word being loaded
  localparam logic [BANK_W-1:0] SEL_EXT_WORD  = 3'h1;
  localparam logic [BANK_W-1:0] SEL_EXT2_WORD = 3'h2;

  // ------------------------------------------------------------------
  // field positions of the extended configuration word
  // ------------------------------------------------------------------
  localparam int unsigned DLL_DISABLE_BIT     = 0;
  localparam int unsigned REDUCED_DRIVE_BIT   = 1;
  localparam int unsigned RTT_LO_BIT          = 2;
  localparam int unsigned AL_LSB              = 3;
  localparam int unsigned RTT_HI_BIT          = 6;
  localparam int unsigned CAL_LSB             = 7;
  localparam int unsigned STROBE_COMP_DIS_BIT = 10;
  localparam int unsigned READ_STROBE_EN_BIT  = 11;
  localparam int unsigned OUTPUT_DIS_BIT      = 12;
  // field position of the second extended word
  localparam int unsigned FAST_REFRESH_BIT    = 7;

  // ------------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------------
  localparam logic [CFG_W-1:0] EXT_WORD_RESET  = 13'h0000;
  localparam logic [CFG_W-1:0] EXT2_WORD_RESET = 13'h0000;
  localparam logic [AL_W-1:0]  AL_MAX          = 3'h6;
  localparam logic [CAL_W-1:0] CAL_DEFAULT     = 3'h7;

  // termination select {E6, E2} and the code driven out
  localparam logic [RTT_W-1:0] RTT_OFF  = 2'h0;
  localparam logic [RTT_W-1:0] RTT_75   = 2'h1;
  localparam logic [RTT_W-1:0] RTT_150  = 2'h2;
  localparam logic [RTT_W-1:0] RTT_50   = 2'h3;

  // power state reported by the core
  localparam logic [PWR_W-1:0] PWR_ACTIVE       = 2'h0;
  localparam logic [PWR_W-1:0] PWR_ACTIVE_PD    = 2'h1;
  localparam logic [PWR_W-1:0] PWR_PRECHARGE_PD = 2'h2;
  localparam logic [PWR_W-1:0] PWR_OTHER        = 2'h3;
endpackage
`default_nettype wire

// *** logic/posted_command_delay.sv ***
/*
  Delay line that holds an accepted READ or WRITE for the programmed added
  command delay before it is issued internally.
  Assumes the delay value is quasi-static (changed only while idle).
*/
`timescale 1ns/10ps
`default_nettype none
module posted_command_delay (
  input  wire logic                                 clk_in,
  input  wire logic                                 rst_b_in,
  input  wire logic [ddr_ext_cfg_pkg::AL_W-1:0]     delay_in,
  input  wire logic                                 cmd_valid_in,
  input  wire logic                                 cmd_write_in,
  input  wire logic [ddr_ext_cfg_pkg::POST_W-1:0]   cmd_addr_in,
  output logic                                      issue_valid_out,
  output logic                                      issue_write_out,
  output logic [ddr_ext_cfg_pkg::POST_W-1:0]        issue_addr_out
);
  localparam int unsigned ENTRY_W = ddr_ext_cfg_pkg::POST_W + 2;

  logic [ENTRY_W-1:0] stage_q [ddr_ext_cfg_pkg::AL_STAGES];
  logic [ENTRY_W-1:0] entry_in;
  logic [ENTRY_W-1:0] pick;
  logic [ddr_ext_cfg_pkg::AL_W-1:0] delay_clamped;

  assign entry_in = {cmd_valid_in, cmd_write_in, cmd_addr_in};
  // reserved delays clamp to the longest so the index never leaves the line
  assign delay_clamped = (delay_in > ddr_ext_cfg_pkg::AL_MAX) ? ddr_ext_cfg_pkg::AL_MAX
                                                              : delay_in;

  // ------------------------------------------------------------------
  // shift stages, one per clock of delay
  // ------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < ddr_ext_cfg_pkg::AL_STAGES; i++) begin : g_stage
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          stage_q[i] <= '0;
        end else begin
          stage_q[i] <= (i == 0) ? entry_in : stage_q[(i == 0) ? 0 : i - 1];
        end
      end
    end
  endgenerate

  // tap select: zero delay bypasses the line
  always_comb begin
    if (delay_clamped == '0) begin
      pick = entry_in;
    end else begin
      pick = stage_q[delay_clamped - 3'h1];
    end
  end

  // issue register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      issue_valid_out <= 1'b0;
      issue_write_out <= 1'b0;
      issue_addr_out  <= '0;
    end else begin
      issue_valid_out <= pick[ENTRY_W-1];
      issue_write_out <= pick[ENTRY_W-2];
      issue_addr_out  <= pick[ddr_ext_cfg_pkg::POST_W-1:0];
    end
  end
endmodule
`default_nettype wire

// *** logic/ext_config_decode.sv ***
/*
  Extended configuration decode of a double-data-rate memory device: catches
  load-configuration commands on the command clock, holds both extended words
  and turns them into strobe, output, termination, loop and latency controls.
  Assumes the command bus is sampled on link_clk_in, the core runs on
  ref_clk_in, and the main configuration word supplies the column latency.
*/
// Overview of operation
// - words change only on a load command and hold until the next one
// - the alignment loop follows the inverse of its disable bit of the loaded word
// - loop turns off in self refresh, re-enables and resets on exit
// - drive bit low gives full drive, high gives about half
// - complement pin mirrors the strobe unless disabled, then strobe is single
// - read strobe complement needs read strobe on and complement enabled
// - x8 read strobe copies the data strobe on reads, ignored on writes
// - output disable bit turns off all data and strobe outputs
// - two bits jointly pick 50, 75 or 150 ohm termination
// - termination pin acts only if enabled and in active or power-down
// - added command delay comes from three bits, 0 to 6 clocks
// - early read or write is held for the added delay before executing
// - read latency is added delay plus column latency, write one less
`timescale 1ns/10ps
`default_nettype none
module ext_config_decode (
  input  wire logic                                 ref_clk_in,
  input  wire logic                                 rst_b_in,
  input  wire logic                                 link_clk_in,
  input  wire logic                                 cmd_select_b_in,
  input  wire logic                                 row_strobe_b_in,
  input  wire logic                                 col_strobe_b_in,
  input  wire logic                                 write_strobe_b_in,
  input  wire logic [ddr_ext_cfg_pkg::BANK_W-1:0]   bank_addr_in,
  input  wire logic [ddr_ext_cfg_pkg::ADDR_W-1:0]   addr_in,
  input  wire logic                                 is_x8_in,
  input  wire logic [ddr_ext_cfg_pkg::CL_W-1:0]     column_read_latency_in,
  input  wire logic                                 self_refresh_in,
  input  wire logic [ddr_ext_cfg_pkg::PWR_W-1:0]    power_state_in,
  input  wire logic                                 termination_control_pin_in,
  input  wire logic                                 data_strobe_in,
  input  wire logic                                 read_burst_in,
  input  wire logic                                 write_burst_in,
  output logic                                      issue_valid_out,
  output logic                                      issue_write_out,
  output logic [ddr_ext_cfg_pkg::POST_W-1:0]        issue_addr_out,
  output logic                                      dll_enable_out,
  output logic                                      dll_reset_out,
  output logic                                      reduced_drive_out,
  output logic [ddr_ext_cfg_pkg::RTT_W-1:0]         termination_select_out,
  output logic                                      termination_on_out,
  output logic                                      calibration_default_out,
  output logic [ddr_ext_cfg_pkg::AL_W-1:0]          added_command_delay_out,
  output logic [ddr_ext_cfg_pkg::LAT_W-1:0]         total_read_latency_out,
  output logic [ddr_ext_cfg_pkg::LAT_W-1:0]         total_write_latency_out,
  output logic                                      fast_refresh_out,
  output logic                                      data_oe_out,
  output logic                                      data_strobe_oe_out,
  output logic                                      strobe_complement_out,
  output logic                                      strobe_complement_oe_out,
  output logic                                      read_only_strobe_out,
  output logic                                      read_only_strobe_oe_out,
  output logic                                      read_only_strobe_complement_out,
  output logic                                      read_only_strobe_complement_oe_out
);
  // ------------------------------------------------------------------
  // link domain: reset release and command decode
  // ------------------------------------------------------------------
  logic                                 link_rst_meta_q;
  logic                                 link_rst_b_q;
  logic [ddr_ext_cfg_pkg::CMD_W-1:0]    cmd_code;
  logic                                 load_config_command;
  logic                                 col_cmd;
  logic [ddr_ext_cfg_pkg::CFG_W-1:0]    ext_word_link_q;
  logic [ddr_ext_cfg_pkg::CFG_W-1:0]    ext2_word_link_q;
  logic                                 load_toggle_q;

  // reset leaves the link domain only on a link edge, so release is clean
  always_ff @(posedge link_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      link_rst_meta_q <= 1'b0;
      link_rst_b_q    <= 1'b0;
    end else begin
      link_rst_meta_q <= 1'b1;
      link_rst_b_q    <= link_rst_meta_q;
    end
  end

  assign cmd_code = {row_strobe_b_in, col_strobe_b_in, write_strobe_b_in};
  assign load_config_command = !cmd_select_b_in &&
                               (cmd_code == ddr_ext_cfg_pkg::CMD_LOAD_CONFIG);
  assign col_cmd = !cmd_select_b_in && ((cmd_code == ddr_ext_cfg_pkg::CMD_READ) ||
                                        (cmd_code == ddr_ext_cfg_pkg::CMD_WRITE));

  // word store: only a load command addressed to the word changes it
  always_ff @(posedge link_clk_in or negedge link_rst_b_q) begin
    if (!link_rst_b_q) begin
      ext_word_link_q  <= ddr_ext_cfg_pkg::EXT_WORD_RESET;
      ext2_word_link_q <= ddr_ext_cfg_pkg::EXT2_WORD_RESET;
    end else if (load_config_command) begin
      if (bank_addr_in == ddr_ext_cfg_pkg::SEL_EXT_WORD) begin
        ext_word_link_q <= addr_in;
      end
      if (bank_addr_in == ddr_ext_cfg_pkg::SEL_EXT2_WORD) begin
        ext2_word_link_q <= addr_in;
      end
    end
  end

  // one toggle per load of either word tells the core to copy both
  always_ff @(posedge link_clk_in or negedge link_rst_b_q) begin
    if (!link_rst_b_q) begin
      load_toggle_q <= 1'b0;
    end else if (load_config_command &&
                 ((bank_addr_in == ddr_ext_cfg_pkg::SEL_EXT_WORD) ||
                  (bank_addr_in == ddr_ext_cfg_pkg::SEL_EXT2_WORD))) begin
      load_toggle_q <= !load_toggle_q;
    end
  end

  // ------------------------------------------------------------------
  // link domain: posted read and write
  // ------------------------------------------------------------------
  // early column commands wait out the added delay before issue
  posted_command_delay u_post (
    .clk_in          (link_clk_in),
    .rst_b_in        (link_rst_b_q),
    .delay_in        (ext_word_link_q[ddr_ext_cfg_pkg::AL_LSB +: ddr_ext_cfg_pkg::AL_W]),
    .cmd_valid_in    (col_cmd),
    .cmd_write_in    (!write_strobe_b_in),
    .cmd_addr_in     ({bank_addr_in, addr_in}),
    .issue_valid_out (issue_valid_out),
    .issue_write_out (issue_write_out),
    .issue_addr_out  (issue_addr_out)
  );

  // ------------------------------------------------------------------
  // core domain: word crossing
  // ------------------------------------------------------------------
  logic                              toggle_meta_q;
  logic                              toggle_sync_q;
  logic                              toggle_seen_q;
  logic [ddr_ext_cfg_pkg::CFG_W-1:0] ext_word_q;
  logic [ddr_ext_cfg_pkg::CFG_W-1:0] ext2_word_q;

  // toggle synchroniser; the words are stable for the load interval after it
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      toggle_meta_q <= 1'b0;
      toggle_sync_q <= 1'b0;
      toggle_seen_q <= 1'b0;
    end else begin
      toggle_meta_q <= load_toggle_q;
      toggle_sync_q <= toggle_meta_q;
      toggle_seen_q <= toggle_sync_q;
    end
  end

  // copy on each seen toggle, relying on the wait after a load
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ext_word_q  <= ddr_ext_cfg_pkg::EXT_WORD_RESET;
      ext2_word_q <= ddr_ext_cfg_pkg::EXT2_WORD_RESET;
    end else if (toggle_sync_q != toggle_seen_q) begin
      ext_word_q  <= ext_word_link_q;
      ext2_word_q <= ext2_word_link_q;
    end
  end

  // ------------------------------------------------------------------
  // core domain: pin synchroniser and self refresh tracking
  // ------------------------------------------------------------------
  logic odt_meta_q;
  logic odt_sync_q;
  logic self_refresh_q;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      odt_meta_q <= 1'b0;
      odt_sync_q <= 1'b0;
    end else begin
      odt_meta_q <= termination_control_pin_in;
      odt_sync_q <= odt_meta_q;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      self_refresh_q <= 1'b0;
    end else begin
      self_refresh_q <= self_refresh_in;
    end
  end

  // ------------------------------------------------------------------
  // core domain: field decode
  // ------------------------------------------------------------------
  logic                                 outputs_off;
  logic                                 complement_on;
  logic                                 read_strobe_on;
  logic [ddr_ext_cfg_pkg::RTT_W-1:0]    rtt_code;
  logic                                 pwr_allows_odt;
  logic [ddr_ext_cfg_pkg::LAT_W-1:0]    read_lat_d;

  assign outputs_off    = ext_word_q[ddr_ext_cfg_pkg::OUTPUT_DIS_BIT];
  assign complement_on  = !ext_word_q[ddr_ext_cfg_pkg::STROBE_COMP_DIS_BIT];
  // read strobe pin exists on x8 parts only
  assign read_strobe_on = ext_word_q[ddr_ext_cfg_pkg::READ_STROBE_EN_BIT] && is_x8_in;
  assign rtt_code       = {ext_word_q[ddr_ext_cfg_pkg::RTT_HI_BIT],
                           ext_word_q[ddr_ext_cfg_pkg::RTT_LO_BIT]};
  assign pwr_allows_odt = (power_state_in == ddr_ext_cfg_pkg::PWR_ACTIVE) ||
                          (power_state_in == ddr_ext_cfg_pkg::PWR_ACTIVE_PD) ||
                          (power_state_in == ddr_ext_cfg_pkg::PWR_PRECHARGE_PD);
  // widths: 3-bit delay plus 3-bit latency fits in 4 bits
  assign read_lat_d = {1'b0, ext_word_q[ddr_ext_cfg_pkg::AL_LSB +: ddr_ext_cfg_pkg::AL_W]} +
                      {1'b0, column_read_latency_in};

  // loop enable drops in self refresh; exit gives a one-cycle reset
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dll_enable_out <= 1'b0;
      dll_reset_out  <= 1'b0;
    end else begin
      dll_enable_out <= !ext_word_q[ddr_ext_cfg_pkg::DLL_DISABLE_BIT] &&
                        !self_refresh_in;
      dll_reset_out  <= self_refresh_q && !self_refresh_in;
    end
  end

  // static controls taken straight from the words
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reduced_drive_out       <= 1'b0;
      termination_select_out  <= ddr_ext_cfg_pkg::RTT_OFF;
      calibration_default_out <= 1'b0;
      added_command_delay_out <= '0;
      fast_refresh_out        <= 1'b0;
    end else begin
      reduced_drive_out       <= ext_word_q[ddr_ext_cfg_pkg::REDUCED_DRIVE_BIT];
      termination_select_out  <= rtt_code;
      calibration_default_out <= (ext_word_q[ddr_ext_cfg_pkg::CAL_LSB +: ddr_ext_cfg_pkg::CAL_W]
                                  == ddr_ext_cfg_pkg::CAL_DEFAULT);
      added_command_delay_out <= ext_word_q[ddr_ext_cfg_pkg::AL_LSB +: ddr_ext_cfg_pkg::AL_W];
      fast_refresh_out        <= ext2_word_q[ddr_ext_cfg_pkg::FAST_REFRESH_BIT];
    end
  end

  // latencies; write latency is one less than read, floored at zero
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      total_read_latency_out  <= '0;
      total_write_latency_out <= '0;
    end else begin
      total_read_latency_out  <= read_lat_d;
      total_write_latency_out <= (read_lat_d == '0) ? '0 : read_lat_d - 4'h1;
    end
  end

  // termination pin gated by enable and by power state
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      termination_on_out <= 1'b0;
    end else begin
      termination_on_out <= (rtt_code != ddr_ext_cfg_pkg::RTT_OFF) && odt_sync_q &&
                            pwr_allows_odt;
    end
  end

  // ------------------------------------------------------------------
  // core domain: strobe and output pins
  // ------------------------------------------------------------------
  // data strobe runs during read bursts only; write strobes are never driven
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_oe_out        <= 1'b0;
      data_strobe_oe_out <= 1'b0;
    end else begin
      data_oe_out        <= read_burst_in && !outputs_off;
      data_strobe_oe_out <= read_burst_in && !outputs_off;
    end
  end

  // complement of the data strobe
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      strobe_complement_out    <= 1'b1;
      strobe_complement_oe_out <= 1'b0;
    end else begin
      strobe_complement_out    <= !data_strobe_in;
      strobe_complement_oe_out <= complement_on && read_burst_in && !outputs_off;
    end
  end

  // read-only strobe copies the data strobe on reads; writes leave it alone
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      read_only_strobe_out    <= 1'b0;
      read_only_strobe_oe_out <= 1'b0;
    end else begin
      read_only_strobe_out    <= data_strobe_in;
      read_only_strobe_oe_out <= read_strobe_on && read_burst_in && !write_burst_in &&
                                 !outputs_off;
    end
  end

  // its complement needs both the read strobe and the complement enabled
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      read_only_strobe_complement_out    <= 1'b1;
      read_only_strobe_complement_oe_out <= 1'b0;
    end else begin
      read_only_strobe_complement_out    <= !data_strobe_in;
      read_only_strobe_complement_oe_out <= read_strobe_on && complement_on && read_burst_in &&
                                            !write_burst_in && !outputs_off;
    end
  end
endmodule
`default_nettype wire

// *** bench/ext_config_decode_assertions.sv ***
/* port assertions for ext_config_decode; assumes it is bound to every instance of it */
`timescale 1ns/10ps
`default_nettype none
module ext_config_decode_assertions (
  input wire logic       ref_clk_in, rst_b_in, self_refresh_in, read_burst_in, write_burst_in,
  input wire logic       is_x8_in, data_strobe_in, dll_enable_out, data_oe_out,
  input wire logic       data_strobe_oe_out, termination_on_out, strobe_complement_out,
  input wire logic       strobe_complement_oe_out, read_only_strobe_out, read_only_strobe_oe_out,
  input wire logic       read_only_strobe_complement_oe_out,
  input wire logic [1:0] termination_select_out,
  input wire logic [2:0] added_command_delay_out,
  input wire logic [3:0] total_read_latency_out, total_write_latency_out
);
  // all checked outputs are registered on the core clock
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_sr_off; self_refresh_in |=> !dll_enable_out; endproperty
  a_sr_off: assert property (p_sr_off) else $error("loop still on in self refresh");
  property p_wl; total_read_latency_out != 4'h0
    |-> total_write_latency_out == total_read_latency_out - 4'h1; endproperty
  a_wl: assert property (p_wl) else $error("write latency not one below read");
  property p_al; added_command_delay_out <= 3'h6; endproperty
  a_al: assert property (p_al) else $error("added delay above six");
  property p_oe; data_oe_out |-> $past(read_burst_in); endproperty
  a_oe: assert property (p_oe) else $error("data driven outside a read");
  property p_comp; strobe_complement_oe_out
    |-> data_strobe_oe_out && strobe_complement_out != $past(data_strobe_in); endproperty
  a_comp: assert property (p_comp) else $error("complement not inverse of strobe");
  property p_ros; read_only_strobe_oe_out |-> $past(is_x8_in && read_burst_in && !write_burst_in)
    && read_only_strobe_out == $past(data_strobe_in); endproperty
  a_ros: assert property (p_ros) else $error("read strobe wrong");
  property p_rosc; read_only_strobe_complement_oe_out
    |-> read_only_strobe_oe_out && strobe_complement_oe_out; endproperty
  a_rosc: assert property (p_rosc) else $error("read strobe complement wrong");
  property p_term; termination_on_out |-> termination_select_out != 2'h0; endproperty
  a_term: assert property (p_term) else $error("termination on while off");
endmodule
bind ext_config_decode ext_config_decode_assertions i_chk (.ref_clk_in, .rst_b_in,
  .self_refresh_in, .read_burst_in, .write_burst_in, .is_x8_in, .data_strobe_in, .dll_enable_out,
  .data_oe_out, .data_strobe_oe_out, .termination_on_out, .strobe_complement_out,
  .strobe_complement_oe_out, .read_only_strobe_out, .read_only_strobe_oe_out,
  .read_only_strobe_complement_oe_out, .termination_select_out, .added_command_delay_out,
  .total_read_latency_out, .total_write_latency_out);
`default_nettype wire

// *** bench/cmd_bus_model.sv ***
/* controller model on the command bus; assumes the bench runs link_clk_in freely */
`timescale 1ns/10ps
`default_nettype none
module cmd_bus_model (
  input  wire logic   link_clk_in,
  output logic [3:0]  cmd_b_out,
  output logic [2:0]  bank_out,
  output logic [12:0] addr_out
);
  // deselected at start so nothing is captured during reset
  initial {cmd_b_out, bank_out, addr_out} = 20'hf0000;
  // one command for one link cycle; released lines show the inverse
  task automatic send(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a);
    @(negedge link_clk_in);
    cmd_b_out = c;
    bank_out = (c == 4'h0) ? {1'b0, b[1:0]} : b;
    addr_out = a;
    @(negedge link_clk_in);
    {cmd_b_out, bank_out, addr_out} = {4'hf, ~b, ~a};
  endtask
endmodule
`default_nettype wire

// *** bench/ext_config_decode_tb.sv ***
/* bench for ext_config_decode; assumes checker and bus model are compiled before it */
`timescale 1ns/10ps
`default_nettype none
module ext_config_decode_tb;
  logic        clk = 0, lclk = 0, rst_b = 0, rd = 0, wr = 0, x8 = 0, dqs = 0, sr = 0, termination_control_pin = 0;
  logic        iv, iw, dle, dlr, red, ton, cal, frf, doe, soe, sc, sco, ro, roo, rc, rco;
  logic [1:0]  pwr = 2'h0, tsel;
  logic [2:0]  bank, al, cl = 3'h4;
  logic [3:0]  cmd, rl, wl;
  logic [12:0] addr;
  logic [15:0] ia;
  int          err_total = 0, total_checks = 0;
  // core clock and an unrelated command clock
  initial forever #2 clk = ~clk;
  initial begin #5; forever #16 lclk = ~lclk; end
  cmd_bus_model i_ctrl (.link_clk_in(lclk), .cmd_b_out(cmd), .bank_out(bank), .addr_out(addr));
  ext_config_decode i_dut (.ref_clk_in(clk), .rst_b_in(rst_b), .link_clk_in(lclk),
    .cmd_select_b_in(cmd[3]), .row_strobe_b_in(cmd[2]), .col_strobe_b_in(cmd[1]),
    .write_strobe_b_in(cmd[0]), .bank_addr_in(bank), .addr_in(addr), .is_x8_in(x8),
    .column_read_latency_in(cl), .self_refresh_in(sr), .power_state_in(pwr),
    .termination_control_pin_in(termination_control_pin), .data_strobe_in(dqs), .read_burst_in(rd),
    .write_burst_in(wr), .issue_valid_out(iv), .issue_write_out(iw), .issue_addr_out(ia),
    .dll_enable_out(dle), .dll_reset_out(dlr), .reduced_drive_out(red),
    .termination_select_out(tsel), .termination_on_out(ton), .calibration_default_out(cal),
    .added_command_delay_out(al), .total_read_latency_out(rl), .total_write_latency_out(wl),
    .fast_refresh_out(frf), .data_oe_out(doe), .data_strobe_oe_out(soe),
    .strobe_complement_out(sc), .strobe_complement_oe_out(sco), .read_only_strobe_out(ro),
    .read_only_strobe_oe_out(roo), .read_only_strobe_complement_out(rc),
    .read_only_strobe_complement_oe_out(rco));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin err_total++; $display("FAIL %0t got %h exp %h", $time, g, e); end
  endtask
  task automatic w(input int n); repeat (n) @(negedge clk); endtask
  // load a word; let the crossing land
  task automatic ld(input logic [2:0] b, input logic [12:0] a);
    i_ctrl.send(4'h0, b, a);
    repeat (3) @(negedge lclk);
    w(1);
  endtask
  task automatic t_fields;
    logic [12:0] v [4] = '{13'h0002, 13'h03b4, 13'h0049, 13'h0064};
    logic [3:0] r;
    chk({dle, red, tsel, al, frf}, 16'h0080);
    foreach (v[i]) begin
      ld(3'h1, v[i]);
      r = {1'b0, v[i][5:3]} + {1'b0, cl};
      chk({dle, red, tsel, al, cal, rl, wl},
        {~v[i][0], v[i][1], v[i][6], v[i][2], v[i][5:3], &v[i][9:7], r, r - 4'h1});
    end
    ld(3'h0, 13'h0100);
    ld(3'h2, 13'h0080);
    chk({dle, red, tsel, al, cal, frf}, {1'b1, 1'b0, 2'h3, 3'h4, 1'b0, 1'b1});
    $display("fields test done");
  endtask
  task automatic t_post;
    ld(3'h1, 13'h0010);
    w(1600);
    for (int k = 0; k < 2; k++) begin
      i_ctrl.send(4'h5 - 4'(k), 3'h5, 13'h0123);
      repeat (2) begin chk(iv, 1'b0); @(negedge lclk); end
      chk(ia, 16'ha123);
      chk({iv, iw}, {1'b1, k[0]});
    end
    $display("posting test done");
  endtask
  task automatic t_strobe;
    logic [12:0] v [3] = '{13'h0800, 13'h0c00, 13'h1800};
    logic a, b;
    foreach (v[i]) begin
      rd = 0;
      ld(3'h1, v[i]);
      {rd, x8, dqs} = 3'h7;
      w(3);
      a = ~v[i][12];
      b = a & ~v[i][10];
      chk({doe, soe, sco, roo, rco}, {a, a, b, a & v[i][11], b & v[i][11]});
      chk({sc, ro, rc}, 3'h2);
      wr = 1;
      w(3);
      chk(roo, 1'b0);
      wr = 0;
    end
    rd = 0;
    $display("strobe test done");
  endtask
  // termination is on with the pin high in three of the four power states
  task automatic t_term;
    ld(3'h1, 13'h0004);
    w(64);
    termination_control_pin = 1;
    for (int p = 3; p >= 0; p--) begin pwr = 2'(p); w(6); chk({tsel, ton}, {2'h1, p != 3}); end
    ld(3'h1, 13'h0000);
    chk(ton, 1'b0);
    termination_control_pin = 0;
    $display("termination test done");
  endtask
  task automatic t_sr;
    int n = 0;
    sr = 1;
    w(4);
    chk(dle, 1'b0);
    sr = 0;
    repeat (10) begin w(1); n += dlr; end
    chk({15'(n), dle}, 16'h3);
    $display("self refresh test done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1;
    repeat (3) @(negedge lclk);
    w(2);
    t_fields; t_post; t_strobe; t_term; t_sr;
    test_done;
  end
  // watchdog well past the run length
  initial begin #80000; err_total++; test_done; end
endmodule
`default_nettype wire
